// ### design/ats_cfg.svh
// Offsets, field positions, reset values and timing counts of the acquisition time base
`ifndef ATS_CFG_SVH
`define ATS_CFG_SVH
`define ATS_CTL_RANGE_BIT 9
`define ATS_REG_CTRL 4'h0
`define ATS_REG_DIV 4'h1
`define ATS_REG_PRE 4'h2
`define ATS_REG_POST 4'h3
`define ATS_REG_HOLDOFF 4'h4
`define ATS_REG_DELAY 4'h5
`define ATS_REG_PATTERN 4'h6
`define ATS_REG_DURMIN 4'h7
`define ATS_REG_DURMAX 4'h8
`define ATS_REG_STATUS 4'h9
`define ATS_REG_ICOUNT 4'ha
`define ATS_CTRL_START 0
`define ATS_CTRL_HALF 1
`define ATS_CTRL_OUTPH 2
`define ATS_CTRL_MODE 3
`define ATS_CTRL_SRC 5
`define ATS_RST_DIV 16'h0001
`define ATS_RST_PRE 16'h0010
`define ATS_RST_POST 16'h0010
`define ATS_REF_MHZ 125
`define ATS_CLK_PS 4000
`define ATS_DLY_MIN_PS 1500
`define ATS_DLY_MAX_PS 20000
`define ATS_STRETCH 1000
`define ATS_LOCK_CYCLES 64
`endif

// ### design/ats_divider.sv
// Programmable sample-rate divider with reference lock indication
`timescale 1ns/1ps
`include "ats_cfg.svh"
module ats_divider import ats_pkg::*; #(
	parameter int DW = 16,
	parameter int LOCK = `ATS_LOCK_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Control
	input wire logic en,
	input wire logic [DW-1:0] div,
	// Result
	output logic tick,
	output logic locked
);
	logic [DW-1:0] cnt_r;
	logic [15:0] lock_r;
	wire logic [DW-1:0] last = (div == '0) ? '0 : div - DW'(1);
	wire logic wrap = (cnt_r >= last);

	// Divisor chosen from the time range gives each slower rate; see RULE4
	always_ff @(posedge mclk) begin
		if (srst || !en) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= wrap ? '0 : cnt_r + DW'(1);
		end
	end

	// Sample clock counted as locked after a run of reference edges; see RULE2
	always_ff @(posedge mclk) begin
		if (srst || !en) begin
			lock_r <= 16'h0000;
		end else if (lock_r != 16'(LOCK)) begin
			lock_r <= lock_r + 16'h0001;
		end
	end

	assign tick = en && wrap && locked;
	assign locked = (lock_r == 16'(LOCK));
endmodule

// ### design/ats_pkg.sv
// Types shared by the acquisition time base modules
package ats_pkg;
	typedef enum logic [1:0] {ATS_TM_EDGE = 2'h0, ATS_TM_GLITCH = 2'h1, ATS_TM_PATTERN = 2'h2} ats_tmode_t;
	typedef enum logic [2:0] {
		ATS_IDLE = 3'h0, ATS_PRE = 3'h1, ATS_ARMED = 3'h3, ATS_POST = 3'h2, ATS_DONE = 3'h6
	} ats_state_t;
	typedef struct packed {
		ats_tmode_t mode;
		logic [1:0] src;
		logic [3:0] pattern;
		logic [3:0] mask;
		logic [15:0] holdoff;
		logic [15:0] delay;
		logic [15:0] dur_min;
		logic [15:0] dur_max;
	} ats_trig_cfg_t;
	typedef struct packed {
		logic half_mode;
		logic out_phase;
		logic quadrature;
		logic [7:0] route;
		logic [15:0] decim;
	} ats_conv_t;
endpackage

// ### design/ats_timebase.sv
// Acquisition time base and trigger sequencer with host port
//
// Overview of operation
// RULE1: converter halves run in or out of phase
// RULE2: sample clock locked to the reference clock
// RULE3: slow rates decimate, converters keep full speed
// RULE4: other rates come from programmable reference division
// RULE5: pretrigger_ready asserted after enough pre-trigger samples
// RULE6: met condition returns qualified_trigger_event to timebase
// RULE7: post-trigger countdown stops clocks, flags completion
// RULE8: pulse spans trigger to next sample edge
// RULE9: interpolator stretches that pulse about 1000 times
// RULE10: counter runs during stretch, halts on completion
// RULE11: halted interpolation count is kept for positioning
// RULE12: trigger mode chosen from edge, glitch, pattern
// RULE13: holdoff, delay and pattern duration range qualification
// RULE14: delay timers span 1.5 to 20 ns; code clamps the delay to 1 to 5 clock cycles, i.e. 4 to 20 ns
// RULE15: full mode gives each channel its own pair
// RULE16: half mode: odd channel feeds both pairs, 90 degrees
// RULE17: host port: 16 data, 10 address, direction, strobes
// RULE18: data read strobe ignores the latched address
// RULE19: three status lines out, two control lines in
// RULE20: address space split into data and control ranges
// RULE21: trigger ignored until pretrigger_ready for this acquisition
`timescale 1ns/1ps
`include "ats_cfg.svh"
module ats_timebase import ats_pkg::*; #(
	parameter int AW = 10,
	parameter int DW = 16,
	parameter int STRETCH = `ATS_STRETCH
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Host port pins
	input wire logic [AW-1:0] hp_addr,
	input wire logic hp_rnw,
	input wire logic hp_rd_n,
	input wire logic hp_wr_n,
	input wire logic hp_drd_n,
	input wire logic [DW-1:0] hp_data_in,
	output logic [DW-1:0] hp_data_out,
	output logic hp_data_oe,
	// Acquisition memory side
	input wire logic [DW-1:0] acq_data,
	output logic [AW-1:0] acq_addr,
	output logic acq_rd,
	// Trigger pins and control lines
	input wire logic [3:0] ch_trig,
	input wire logic ctl_trig_en,
	input wire logic ctl_clk_run,
	// Time base outputs
	output logic pretrigger_ready,
	output logic qualified_trigger_event,
	output logic sample_clk_en,
	output logic interp_pulse,
	output logic acq_done,
	output logic dll_locked,
	output ats_conv_t conv,
	// Status lines
	output logic stat_run,
	output logic stat_trig,
	output logic stat_interp
);
	// Two-flop synchronisers for every host port, trigger and control input; acq_data is used unsynchronised
	localparam int SW = AW + DW + 4 + 4 + 2;
	logic [SW-1:0] s1_r, s2_r;
	always_ff @(posedge mclk) begin
		s1_r <= {hp_addr, hp_data_in, hp_rnw, hp_rd_n, hp_wr_n, hp_drd_n, ch_trig, ctl_trig_en, ctl_clk_run};
		s2_r <= s1_r;
	end
	wire logic [AW-1:0] a_s = s2_r[SW-1 -: AW];
	wire logic [DW-1:0] d_s = s2_r[SW-AW-1 -: DW];
	wire logic rnw_s = s2_r[9];
	wire logic rd_s = !s2_r[8];
	wire logic wr_s = !s2_r[7];
	wire logic drd_s = !s2_r[6];
	wire logic [3:0] trig_s = s2_r[5:2];
	wire logic trig_en_s = s2_r[1];
	wire logic clk_run_s = s2_r[0];

	// Control state
	logic [DW-1:0] ctrl_r, div_r, pre_r, post_r, icount_r;
	ats_trig_cfg_t tcfg_r;
	logic wr_prev_r, drd_prev_r;
	ats_state_t st_r, st_nxt;
	logic [DW-1:0] pre_cnt_r, post_cnt_r;
	logic ready_r, qte_r, done_r, samp_r, lock_r;
	logic [DW-1:0] rdata_r;
	logic oe_r, acq_rd_r;
	logic [AW-1:0] acq_addr_r;
	logic ipulse_r, stretch_r;
	logic [31:0] pw_r, st_cnt_r, run_cnt_r;
	ats_conv_t conv_r;
	logic run_o_r, trig_o_r, interp_o_r;

	// Host port decode
	wire logic ctl_range = a_s[`ATS_CTL_RANGE_BIT];
	wire logic [3:0] reg_idx = a_s[3:0];
	wire logic wr_go = wr_s && !wr_prev_r && !rnw_s && ctl_range;
	wire logic start_go = wr_go && reg_idx == `ATS_REG_CTRL && d_s[`ATS_CTRL_START];
	wire logic rd_act = rd_s && rnw_s;
	wire logic [DW-1:0] status_w = {9'h000, lock_r, done_r, ready_r, stretch_r, st_r};

	function automatic logic [DW-1:0] reg_read(input logic [3:0] idx);
		case (idx)
			`ATS_REG_CTRL: reg_read = ctrl_r;
			`ATS_REG_DIV: reg_read = div_r;
			`ATS_REG_PRE: reg_read = pre_r;
			`ATS_REG_POST: reg_read = post_r;
			`ATS_REG_HOLDOFF: reg_read = tcfg_r.holdoff;
			`ATS_REG_DELAY: reg_read = tcfg_r.delay;
			`ATS_REG_PATTERN: reg_read = {8'h00, tcfg_r.mask, tcfg_r.pattern};
			`ATS_REG_DURMIN: reg_read = tcfg_r.dur_min;
			`ATS_REG_DURMAX: reg_read = tcfg_r.dur_max;
			`ATS_REG_STATUS: reg_read = status_w;
			`ATS_REG_ICOUNT: reg_read = icount_r;
			default: reg_read = '0;
		endcase
	endfunction

	// Data strobe wins and ignores the address; see RULE18 and RULE20
	wire logic [DW-1:0] rdata_nxt = drd_s ? acq_data : (ctl_range ? reg_read(reg_idx) : acq_data);

	// Host port pins and memory fetch; see RULE17
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata_r <= '0;
			oe_r <= 1'b0;
			acq_rd_r <= 1'b0;
			acq_addr_r <= '0;
			wr_prev_r <= 1'b0;
			drd_prev_r <= 1'b0;
		end else begin
			wr_prev_r <= wr_s;
			drd_prev_r <= drd_s;
			oe_r <= drd_s || rd_act;
			rdata_r <= (drd_s || rd_act) ? rdata_nxt : rdata_r;
			acq_rd_r <= (drd_s && !drd_prev_r) || (rd_act && !ctl_range);
			if (rd_act && !drd_s) begin
				acq_addr_r <= a_s;
			end
		end
	end

	// Control elements written in the control range
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_r <= '0;
			div_r <= `ATS_RST_DIV;
			pre_r <= `ATS_RST_PRE;
			post_r <= `ATS_RST_POST;
			tcfg_r <= '0;
		end else if (wr_go) begin
			case (reg_idx)
				`ATS_REG_CTRL: ctrl_r <= d_s;
				`ATS_REG_DIV: div_r <= d_s;
				`ATS_REG_PRE: pre_r <= d_s;
				`ATS_REG_POST: post_r <= d_s;
				`ATS_REG_HOLDOFF: tcfg_r.holdoff <= d_s;
				`ATS_REG_DELAY: tcfg_r.delay <= d_s;
				`ATS_REG_PATTERN: {tcfg_r.mask, tcfg_r.pattern} <= d_s[7:0];
				`ATS_REG_DURMIN: tcfg_r.dur_min <= d_s;
				`ATS_REG_DURMAX: tcfg_r.dur_max <= d_s;
				default: ;
			endcase
			if (reg_idx == `ATS_REG_CTRL) begin
				tcfg_r.mode <= ats_tmode_t'(d_s[`ATS_CTRL_MODE +: 2]);
				tcfg_r.src <= d_s[`ATS_CTRL_SRC +: 2];
			end
		end
	end

	// Sample clock divider and trigger qualifier
	wire logic running = (st_r == ATS_PRE) || (st_r == ATS_ARMED) || (st_r == ATS_POST);
	wire logic clk_en = running && clk_run_s;
	logic tick, locked, hit;
	ats_divider #(.DW(DW)) u_div (
		.mclk(mclk),
		.srst(srst),
		.en(clk_en),
		.div(div_r),
		.tick(tick),
		.locked(locked)
	);
	ats_trig_qual u_qual (
		.mclk(mclk),
		.srst(srst),
		.trig(trig_s),
		.cfg(tcfg_r),
		.hit(hit)
	);

	// Trigger honoured only once armed for this acquisition; see RULE6 and RULE21
	wire logic qte = hit && trig_en_s && st_r == ATS_ARMED && ready_r;
	wire logic pre_full = pre_cnt_r >= pre_r;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ATS_IDLE: st_nxt = start_go ? ATS_PRE : ATS_IDLE;
			ATS_PRE: st_nxt = pre_full ? ATS_ARMED : ATS_PRE;
			ATS_ARMED: st_nxt = qte ? ATS_POST : ATS_ARMED;
			ATS_POST: st_nxt = (post_cnt_r == '0) ? ATS_DONE : ATS_POST;
			ATS_DONE: st_nxt = start_go ? ATS_PRE : ATS_DONE;
			default: st_nxt = ATS_IDLE;
		endcase
	end

	// Sequencer: pre-trigger fill, arm, post-trigger countdown
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_r <= ATS_IDLE;
			pre_cnt_r <= '0;
			post_cnt_r <= '0;
			ready_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			if (start_go) begin
				pre_cnt_r <= '0;
				done_r <= 1'b0;
				ready_r <= 1'b0;
			end else if (st_r == ATS_PRE && tick) begin
				pre_cnt_r <= pre_cnt_r + DW'(1);
			end
			if (st_r == ATS_PRE && pre_full) begin
				ready_r <= 1'b1; // see RULE5
			end else if (qte) begin
				ready_r <= 1'b0;
			end
			if (qte) begin
				post_cnt_r <= post_r; // see RULE7
			end else if (st_r == ATS_POST && tick && post_cnt_r != '0) begin
				post_cnt_r <= post_cnt_r - DW'(1);
			end
			if (st_r == ATS_POST && post_cnt_r == '0) begin
				done_r <= 1'b1; // see RULE7
			end
		end
	end

	// Interpolator pulse, stretch and interval count
	wire logic [31:0] stretch_len = pw_r * 32'(STRETCH);
	always_ff @(posedge mclk) begin
		if (srst) begin
			ipulse_r <= 1'b0;
			stretch_r <= 1'b0;
			pw_r <= '0;
			st_cnt_r <= '0;
			run_cnt_r <= '0;
			icount_r <= '0;
		end else begin
			if (qte) begin
				ipulse_r <= 1'b1; // see RULE8
				pw_r <= 32'h0000_0001;
			end else if (ipulse_r && tick) begin
				ipulse_r <= 1'b0;
				stretch_r <= 1'b1;
				st_cnt_r <= 32'h0000_0001;
				run_cnt_r <= '0;
			end else if (ipulse_r) begin
				pw_r <= pw_r + 32'h0000_0001;
			end
			if (stretch_r) begin
				st_cnt_r <= st_cnt_r + 32'h0000_0001; // see RULE9
				run_cnt_r <= run_cnt_r + 32'h0000_0001; // see RULE10
				if (st_cnt_r >= stretch_len) begin
					stretch_r <= 1'b0;
					icount_r <= run_cnt_r[DW-1:0] + DW'(1); // see RULE11
				end
			end
		end
	end

	// Converter setup: phase, decimation and channel routing
	always_ff @(posedge mclk) begin
		if (srst) begin
			conv_r <= '0;
			qte_r <= 1'b0;
			samp_r <= 1'b0;
			lock_r <= 1'b0;
			run_o_r <= 1'b0;
			trig_o_r <= 1'b0;
			interp_o_r <= 1'b0;
		end else begin
			conv_r.half_mode <= ctrl_r[`ATS_CTRL_HALF];
			conv_r.out_phase <= ctrl_r[`ATS_CTRL_OUTPH]; // see RULE1
			conv_r.quadrature <= ctrl_r[`ATS_CTRL_HALF]; // see RULE16
			conv_r.route <= ctrl_r[`ATS_CTRL_HALF] ? 8'h20 : 8'he4; // see RULE15
			conv_r.decim <= (div_r == '0) ? DW'(1) : div_r; // see RULE3
			qte_r <= qte;
			samp_r <= tick && st_r != ATS_DONE;
			lock_r <= locked; // see RULE2
			run_o_r <= running; // see RULE19
			trig_o_r <= (st_r == ATS_POST) || (st_r == ATS_DONE);
			interp_o_r <= ipulse_r || stretch_r;
		end
	end

	assign hp_data_out = rdata_r;
	assign hp_data_oe = oe_r;
	assign acq_addr = acq_addr_r;
	assign acq_rd = acq_rd_r;
	assign pretrigger_ready = ready_r;
	assign qualified_trigger_event = qte_r;
	assign sample_clk_en = samp_r;
	assign interp_pulse = ipulse_r;
	assign acq_done = done_r;
	assign dll_locked = lock_r;
	assign conv = conv_r;
	assign stat_run = run_o_r;
	assign stat_trig = trig_o_r;
	assign stat_interp = interp_o_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_trig_needs_ready: assert property (qte_r |-> $past(ready_r) && !ready_r) // see RULE21
		else $error("trigger accepted while not armed");
	a_ready_after_pre: assert property (st_r == ATS_PRE && pre_full |=> ready_r) // see RULE5
		else $error("pretrigger_ready missing after fill");
	a_post_loaded: assert property (qte |=> st_r == ATS_POST && post_cnt_r == post_r) // see RULE7
		else $error("post counter not loaded on trigger");
	a_done_stops: assert property (st_r == ATS_POST && post_cnt_r == '0 |=> done_r && st_r == ATS_DONE) // see RULE7
		else $error("completion not flagged at zero");
	a_post_counts: assert property (st_r == ATS_POST && tick && post_cnt_r != '0 |=> post_cnt_r == $past(post_cnt_r) - DW'(1)) // see RULE7
		else $error("post counter did not step on sample tick");
	a_done_held: assert property (done_r && !start_go |=> done_r) // see RULE7
		else $error("completion flag dropped without start");
	a_clocks_stop: assert property (st_r == ATS_DONE |=> !samp_r) // see RULE7
		else $error("sample clock runs after completion");
	a_pulse_ends: assert property (ipulse_r && tick && !qte |=> !ipulse_r && stretch_r) // see RULE8
		else $error("interpolator pulse not ended by sample edge");
	a_count_held: assert property (!stretch_r && !$past(stretch_r) |-> $stable(icount_r)) // see RULE11
		else $error("interpolation count changed while idle");
	a_data_strobe: assert property (drd_s |=> rdata_r == $past(acq_data) && oe_r) // see RULE18
		else $error("data strobe did not return acquisition data");
	a_half_route: assert property (ctrl_r[`ATS_CTRL_HALF] |=> conv_r.route == 8'h20 && conv_r.quadrature) // see RULE16
		else $error("half channel routing wrong");
	c_armed: cover property (st_r == ATS_PRE ##[1:1000] st_r == ATS_ARMED);
	c_pattern_trig: cover property (qte && tcfg_r.mode == ATS_TM_PATTERN);
	c_triggered: cover property (qte ##[1:300] done_r);
	c_stretch_end: cover property (stretch_r ##1 !stretch_r);
endmodule

// ### design/ats_trig_qual.sv
// Trigger mode selection, holdoff, delay and duration qualification
`timescale 1ns/1ps
`include "ats_cfg.svh"
module ats_trig_qual import ats_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Channel triggers and setup
	input wire logic [3:0] trig,
	input wire ats_trig_cfg_t cfg,
	// Qualified condition
	output logic hit
);
	localparam logic [15:0] DLY_MIN = 16'((`ATS_DLY_MIN_PS + `ATS_CLK_PS - 1) / `ATS_CLK_PS);
	localparam logic [15:0] DLY_MAX = 16'(`ATS_DLY_MAX_PS / `ATS_CLK_PS);
	logic [3:0] prev_r;
	logic run_prev_r;
	logic [15:0] wid_r, ho_r, dl_r;
	logic hit_r;

	function automatic logic [15:0] clamp_dly(input logic [15:0] d);
		clamp_dly = (d < DLY_MIN) ? DLY_MIN : (d > DLY_MAX) ? DLY_MAX : d;
	endfunction

	wire logic sel = trig[cfg.src];
	wire logic rise = sel && !prev_r[cfg.src];
	wire logic match = (((trig ^ cfg.pattern) & cfg.mask) == 4'h0);
	wire logic run = (cfg.mode == ATS_TM_PATTERN) ? match : sel;
	wire logic end_run = run_prev_r && !run;
	wire logic in_range = (wid_r >= cfg.dur_min) && (wid_r <= cfg.dur_max);
	// Mode picks edge, glitch or pattern; see RULE12
	wire logic cand = (cfg.mode == ATS_TM_EDGE) ? rise :
		(cfg.mode == ATS_TM_GLITCH) ? (end_run && wid_r < cfg.dur_min) :
		(cfg.mode == ATS_TM_PATTERN) ? (end_run && in_range) : 1'b0;
	wire logic start = cand && ho_r == 16'h0000 && dl_r == 16'h0000;

	always_ff @(posedge mclk) begin
		prev_r <= trig;
		run_prev_r <= run;
		wid_r <= run ? ((wid_r == 16'hffff) ? wid_r : wid_r + 16'h0001) : 16'h0000;
	end

	// Holdoff and delay timers qualify the condition; see RULE13 and RULE14
	always_ff @(posedge mclk) begin
		if (srst) begin
			ho_r <= 16'h0000;
			dl_r <= 16'h0000;
			hit_r <= 1'b0;
		end else begin
			hit_r <= (dl_r == 16'h0001);
			if (start) begin
				dl_r <= clamp_dly(cfg.delay);
			end else if (dl_r != 16'h0000) begin
				dl_r <= dl_r - 16'h0001;
			end
			if (dl_r == 16'h0001) begin
				ho_r <= cfg.holdoff;
			end else if (ho_r != 16'h0000) begin
				ho_r <= ho_r - 16'h0001;
			end
		end
	end

	assign hit = hit_r;
endmodule

// ### tb/ats_host_model.sv
// Behavioural system controller driving the host port
`timescale 1ns/1ps
module ats_host_model (
	// Clock
	input wire logic mclk,
	// Host port pins
	output logic [9:0] hp_addr,
	output logic hp_rnw,
	output logic hp_rd_n,
	output logic hp_wr_n,
	output logic hp_drd_n,
	output logic [15:0] hp_data_in,
	input wire logic [15:0] hp_data_out,
	input wire logic hp_data_oe
);
	initial begin
		hp_addr = 10'h000;
		hp_rnw = 1'b1;
		hp_rd_n = 1'b1;
		hp_wr_n = 1'b1;
		hp_drd_n = 1'b1;
		hp_data_in = 16'hffff;
	end

	// Address and data settle 3 cycles before the strobe and stay 3 after it
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge mclk);
		hp_addr <= a;
		hp_rnw <= 1'b0;
		hp_data_in <= d;
		repeat (3) @(posedge mclk);
		hp_wr_n <= 1'b0;
		repeat (4) @(posedge mclk);
		hp_wr_n <= 1'b1;
		repeat (3) @(posedge mclk);
		hp_rnw <= 1'b1;
		hp_data_in <= ~d;
		repeat (3) @(posedge mclk);
	endtask

	// Strobe held until the device drives the data, then taken at that edge
	task automatic rd(input logic [9:0] a, input logic data_strobe, output logic [15:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		hp_addr <= a;
		hp_rnw <= 1'b1;
		repeat (3) @(posedge mclk);
		if (data_strobe) begin
			hp_drd_n <= 1'b0;
		end else begin
			hp_rd_n <= 1'b0;
		end
		do begin
			@(posedge mclk);
			n++;
		end while (hp_data_oe !== 1'b1 && n < 20);
		d = (n < 20) ? hp_data_out : 16'hxxxx;
		hp_rd_n <= 1'b1;
		hp_drd_n <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the acquisition time base
`timescale 1ns/1ps
module tb;
	import ats_pkg::*;
	localparam int STR = 4;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [9:0] hp_addr;
	logic hp_rnw;
	logic hp_rd_n;
	logic hp_wr_n;
	logic hp_drd_n;
	logic [15:0] hp_data_in;
	logic [15:0] hp_data_out;
	logic hp_data_oe;
	logic [15:0] acq_data = 16'h0000;
	logic [9:0] acq_addr;
	logic acq_rd;
	logic [3:0] ch_trig = 4'h0;
	logic ctl_trig_en = 1'b1;
	logic ctl_clk_run = 1'b1;
	logic pretrigger_ready;
	logic qualified_trigger_event;
	logic sample_clk_en;
	logic interp_pulse;
	logic acq_done;
	logic dll_locked;
	ats_conv_t conv;
	logic stat_run;
	logic stat_trig;
	logic stat_interp;
	int fail_count = 0;
	int checked = 0;
	int regs [16];
	int pre_n = 0;
	int post_n = 0;
	int iw = 0;
	int qte_n = 0;
	int rdp_n = 0;
	logic ip_q = 1'b0;
	logic armed_seen = 1'b0;
	logic [15:0] rv;
	int seed;

	always #2 mclk = ~mclk;

	ats_timebase #(.STRETCH(STR)) DUT (.mclk(mclk), .srst(srst), .hp_addr(hp_addr), .hp_rnw(hp_rnw),
		.hp_rd_n(hp_rd_n), .hp_wr_n(hp_wr_n), .hp_drd_n(hp_drd_n), .hp_data_in(hp_data_in),
		.hp_data_out(hp_data_out), .hp_data_oe(hp_data_oe), .acq_data(acq_data), .acq_addr(acq_addr),
		.acq_rd(acq_rd), .ch_trig(ch_trig), .ctl_trig_en(ctl_trig_en), .ctl_clk_run(ctl_clk_run),
		.pretrigger_ready(pretrigger_ready), .qualified_trigger_event(qualified_trigger_event),
		.sample_clk_en(sample_clk_en), .interp_pulse(interp_pulse), .acq_done(acq_done),
		.dll_locked(dll_locked), .conv(conv), .stat_run(stat_run), .stat_trig(stat_trig),
		.stat_interp(stat_interp));

	ats_host_model host (.mclk(mclk), .hp_addr(hp_addr), .hp_rnw(hp_rnw), .hp_rd_n(hp_rd_n),
		.hp_wr_n(hp_wr_n), .hp_drd_n(hp_drd_n), .hp_data_in(hp_data_in), .hp_data_out(hp_data_out),
		.hp_data_oe(hp_data_oe));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Monitors of sample ticks, trigger events and interpolator pulse width
	always @(posedge mclk) begin
		ip_q <= interp_pulse;
		if (acq_rd === 1'b1) begin
			rdp_n <= rdp_n + 1;
		end
		if (interp_pulse === 1'b1) begin
			iw <= (ip_q === 1'b1) ? iw + 1 : 1;
		end
		if (acq_done === 1'b1) begin
			pre_n <= 0;
			armed_seen <= 1'b0;
		end else if (stat_run === 1'b1 && stat_trig !== 1'b1 && pretrigger_ready !== 1'b1 && sample_clk_en === 1'b1) begin
			pre_n <= pre_n + 1;
		end else if (pretrigger_ready === 1'b1) begin
			armed_seen <= 1'b1;
		end
		if (qualified_trigger_event === 1'b1) begin
			qte_n <= qte_n + 1;
			post_n <= 0;
			check(armed_seen, 1'b1);
		end else if (stat_trig === 1'b1 && acq_done !== 1'b1 && sample_clk_en === 1'b1) begin
			post_n <= post_n + 1;
		end
	end

	task automatic wreg(input int i, input logic [15:0] v);
		host.wr({6'h20, i[3:0]}, v);
		regs[i] = v;
	endtask

	task automatic creg(input int i);
		logic [15:0] d;
		host.rd({6'h20, i[3:0]}, 1'b0, d);
		check(d, regs[i][15:0]);
	endtask

	task automatic pulse_trig;
		@(posedge mclk);
		ch_trig <= 4'h1;
		repeat (3) @(posedge mclk);
		ch_trig <= 4'h0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic run(input logic [1:0] cm, input ats_tmode_t tm);
		int dv;
		int pre;
		int post;
		int k;
		int q0;
		dv = $urandom_range(5, 3);
		pre = $urandom_range(15, 12);
		post = $urandom_range(11, 4);
		wreg(1, dv[15:0]);
		wreg(2, pre[15:0]);
		wreg(3, post[15:0]);
		wreg(4, 16'($urandom_range(10, 0)));
		wreg(5, 16'($urandom_range(7, 0)));
		wreg(6, 16'h0011);
		wreg(7, (tm == ATS_TM_GLITCH) ? 16'h0008 : 16'h0002);
		wreg(8, 16'h0006);
		creg(6);
		q0 = qte_n;
		host.wr(10'h200, {9'h000, 2'b00, tm, cm, 1'b1});
		pulse_trig();
		k = 0;
		while (pretrigger_ready !== 1'b1 && k < 2000) begin
			@(posedge mclk);
			k++;
		end
		check(pre_n >= pre - 1 && pre_n <= pre + 1, 1'b1);
		check(stat_run, 1'b1);
		check(qte_n, q0);
		ctl_trig_en <= 1'b0;
		ctl_clk_run <= 1'b0;
		pulse_trig();
		k = 0;
		repeat (20) begin
			@(posedge mclk);
			k += (sample_clk_en === 1'b1) ? 1 : 0;
		end
		check(k, 0);
		check(qte_n, q0);
		ctl_clk_run <= 1'b1;
		repeat (80) @(posedge mclk);
		check(dll_locked, 1'b1);
		ctl_trig_en <= 1'b1;
		pulse_trig();
		k = 0;
		while (acq_done !== 1'b1 && k < 3000) begin
			@(posedge mclk);
			k++;
		end
		check(qte_n, q0 + 1);
		check(post_n >= post - 1 && post_n <= post + 1, 1'b1);
		check(iw >= 1 && iw <= dv, 1'b1);
		k = 0;
		repeat (40) begin
			@(posedge mclk);
			k += (sample_clk_en === 1'b1) ? 1 : 0;
		end
		check(k, 0);
		check({stat_run, stat_trig, stat_interp}, 3'b010);
		host.rd(10'h20a, 1'b0, rv);
		check(rv, iw * STR);
		host.rd(10'h20a, 1'b0, rv);
		check(rv, iw * STR);
		host.rd(10'h209, 1'b0, rv);
		check(rv, 16'h0026);
		check({conv.half_mode, conv.out_phase}, {cm[0], cm[1]});
		check(conv.route, cm[0] ? 8'h20 : 8'he4);
		check(conv.quadrature, cm[0]);
		check(conv.decim, dv);
	endtask

	initial begin
		#40000;
		fail_count++;
		end_sim();
	end

	initial begin
		seed = $urandom(32'h21fa7281);
		regs = '{default: 0};
		regs[1] = 1;
		regs[2] = 16;
		regs[3] = 16;
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		repeat (80) @(posedge mclk);
		check(dll_locked, 1'b0);
		creg(1);
		creg(2);
		creg(3);
		creg(11);
		host.wr(10'h001, 16'h7777);
		creg(1);
		acq_data <= 16'($urandom);
		host.rd(10'h3c5, 1'b1, rv);
		check(rv, acq_data);
		check(rdp_n, 1);
		check(hp_data_oe, 1'b0);
		host.rd(10'h0a7, 1'b0, rv);
		check(rv, acq_data);
		check(acq_addr, 10'h0a7);
		run(2'b00, ATS_TM_EDGE);
		run(2'b11, ATS_TM_PATTERN);
		run(2'b10, ATS_TM_GLITCH);
		end_sim();
	end
endmodule
